// ### hdl/tic_pkg.sv
// Constants and types of the time interval counter.
// Assumes an 8-bit special function register port and one 40 MHz clock.
package tic_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'ha1;
  localparam logic [7:0] OFF_FRAC = 8'ha2;
  localparam logic [7:0] OFF_SEC = 8'ha3;
  localparam logic [7:0] OFF_MIN = 8'ha4;
  localparam logic [7:0] OFF_HOUR = 8'ha5;
  localparam logic [7:0] OFF_TARGET = 8'ha6;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int BIT_TIME_CLOCK_ENABLE = 0;
  localparam int BIT_INTERVAL_ENABLE = 1;
  localparam int BIT_FLAG = 2;
  localparam int BIT_SINGLE = 3;
  localparam int BIT_TB_LO = 4;
  localparam int BIT_TB_HI = 5;
  localparam int BIT_H24 = 6;
  localparam logic [7:0] RST_REG = 8'h00;

  // ****************************************
  // Counting limits and timing
  // ****************************************
  localparam logic [7:0] MAX_FRAC = 8'h7f;
  localparam logic [7:0] MAX_SEC = 8'h3b;
  localparam logic [7:0] MAX_MIN = 8'h3b;
  localparam logic [7:0] MAX_H24 = 8'h17;
  localparam logic [7:0] MAX_H256 = 8'hff;
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_PERIOD_NS = 7_812_500;
  localparam int FRAC_DIV_CYCLES = TICK_PERIOD_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam logic [15:0] IRQ_VECTOR = 16'h0053;

  typedef enum logic [1:0] {
    TB_FRAC = 2'b00,
    TB_SEC = 2'b01,
    TB_MIN = 2'b10,
    TB_HOUR = 2'b11
  } tic_timebase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
  } tic_sfr_req_t;

endpackage

// ### hdl/tic_prescale.sv
// Divider that makes the 1/128 second tick from the core clock.
// Assumes clr_i holds it at zero while the time clock is off.
`timescale 1ns/100ps
module tic_prescale #(
  parameter int DIV = 312500
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  output logic tick_o
);
  import tic_pkg::*;

  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] div_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= '0;
      tick_o <= 1'b0;
    end else if (clr_i) begin
      div_q <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (div_q == LAST);
      div_q <= (div_q == LAST) ? '0 : div_q + W'(1);
    end
  end
endmodule

// ### hdl/tic_modcnt.sv
// Loadable modulo counter used for each time register.
// Assumes load_i only while counting is stopped.
`timescale 1ns/100ps
module tic_modcnt #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  input wire logic inc_i,
  input wire logic [W-1:0] max_i,
  output logic [W-1:0] count_o,
  output logic wrap_o
);
  import tic_pkg::*;

  // Out of range preload still rolls over
  assign wrap_o = inc_i && (count_o >= max_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= '0;
    end else if (clr_i) begin
      count_o <= '0;
    end else if (load_i) begin
      count_o <= load_val_i;
    end else if (inc_i) begin
      count_o <= wrap_o ? '0 : count_o + W'(1);
    end
  end
endmodule

// ### hdl/tic_top.sv
// Time interval counter: cascaded time registers, interval counter, flag.
// Assumes a same-clock register port and interrupt controller inputs.
`timescale 1ns/100ps

module tic_top #(
  parameter int FRAC_DIV = tic_pkg::FRAC_DIV_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire tic_pkg::tic_sfr_req_t sfr_req_i,
  input wire logic irq_enable_i,
  input wire logic core_power_down_i,
  output logic [7:0] sfr_rdata_o,
  output logic irq_o,
  output logic wake_o,
  output logic [15:0] irq_vector_o
);
  import tic_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ****************************************
  // Control register
  // ****************************************
  logic time_clock_enable_q;
  logic interval_enable_q;
  logic flag_q;
  logic single_q;
  logic sel24_q;
  tic_timebase_t tb_q;
  logic [7:0] target_q;
  logic [7:0] ival_q;
  logic ctrl_wr;
  logic time_clock_enable_fall;
  logic timeout;
  logic [7:0] wd;

  assign wd = sfr_req_i.wdata;
  assign ctrl_wr = sfr_req_i.wr && hit(sfr_req_i.addr, OFF_CTRL);
  assign time_clock_enable_fall = ctrl_wr && time_clock_enable_q && !wd[BIT_TIME_CLOCK_ENABLE];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      time_clock_enable_q <= 1'b0;
      single_q <= 1'b0;
      sel24_q <= 1'b0;
      tb_q <= TB_FRAC;
    end else if (ctrl_wr) begin
      time_clock_enable_q <= wd[BIT_TIME_CLOCK_ENABLE];
      single_q <= wd[BIT_SINGLE];
      sel24_q <= wd[BIT_H24];
      tb_q <= tic_timebase_t'(wd[BIT_TB_HI:BIT_TB_LO]);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      interval_enable_q <= 1'b0;
    end else if (ctrl_wr) begin
      interval_enable_q <= wd[BIT_INTERVAL_ENABLE];
    end else if (timeout && single_q) begin
      interval_enable_q <= 1'b0;
    end
  end

  // Match sets flag even on the clearing write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_q <= 1'b0;
    end else if (timeout) begin
      flag_q <= 1'b1;
    end else if (ctrl_wr) begin
      flag_q <= wd[BIT_FLAG];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      target_q <= RST_REG;
    end else if (sfr_req_i.wr && hit(sfr_req_i.addr, OFF_TARGET)) begin
      target_q <= wd;
    end
  end

  // ****************************************
  // Time registers
  // ****************************************
  logic tick128;
  logic [7:0] time_cnt [4];
  logic [3:0] time_wrap;
  logic [3:0] time_inc;
  logic [7:0] time_max [4];

  // Free of the core power-down input
  tic_prescale #(
    .DIV(FRAC_DIV)
  ) u_prescale (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(!time_clock_enable_q),
    .tick_o(tick128)
  );

  assign time_max[0] = MAX_FRAC;
  assign time_max[1] = MAX_SEC;
  assign time_max[2] = MAX_MIN;
  assign time_max[3] = sel24_q ? MAX_H24 : MAX_H256;
  assign time_inc[0] = tick128 && time_clock_enable_q;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_time
      if (gi > 0) begin : g_carry
        assign time_inc[gi] = time_wrap[gi-1];
      end
      tic_modcnt #(
        .W(8)
      ) u_cnt (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .clr_i(time_clock_enable_fall),
        .load_i(sfr_req_i.wr && !time_clock_enable_q &&
                hit(sfr_req_i.addr, OFF_FRAC + 8'(gi))),
        .load_val_i(wd),
        .inc_i(time_inc[gi]),
        .max_i(time_max[gi]),
        .count_o(time_cnt[gi]),
        .wrap_o(time_wrap[gi])
      );
    end
  endgenerate

  // ****************************************
  // Interval counter
  // ****************************************
  logic tick_sel;

  always_comb begin
    case (tb_q)
      TB_FRAC: tick_sel = time_inc[0];
      TB_SEC: tick_sel = time_inc[1];
      TB_MIN: tick_sel = time_inc[2];
      TB_HOUR: tick_sel = time_inc[3];
      default: tick_sel = 1'b0;
    endcase
  end

  assign timeout = interval_enable_q && tick_sel && (ival_q + 8'h01 == target_q);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ival_q <= 8'h00;
    end else if (!interval_enable_q) begin
      ival_q <= 8'h00;
    end else if (timeout) begin
      ival_q <= 8'h00;
    end else if (tick_sel) begin
      ival_q <= ival_q + 8'h01;
    end
  end

  // ****************************************
  // Read port and interrupt outputs
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= RST_REG;
    end else begin
      case (sfr_req_i.addr)
        OFF_CTRL: sfr_rdata_o <= {1'b0, sel24_q, tb_q, single_q, flag_q, interval_enable_q, time_clock_enable_q};
        OFF_FRAC: sfr_rdata_o <= time_cnt[0];
        OFF_SEC: sfr_rdata_o <= time_cnt[1];
        OFF_MIN: sfr_rdata_o <= time_cnt[2];
        OFF_HOUR: sfr_rdata_o <= time_cnt[3];
        OFF_TARGET: sfr_rdata_o <= target_q;
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
      wake_o <= 1'b0;
      irq_vector_o <= 16'h0000;
    end else begin
      irq_o <= flag_q && irq_enable_i;
      wake_o <= flag_q && irq_enable_i && core_power_down_i;
      irq_vector_o <= IRQ_VECTOR;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_frac_carry: assert property (
    time_inc[0] && time_cnt[0] == MAX_FRAC && !ctrl_wr
    |=> time_cnt[0] == 8'h00 && time_cnt[1] != $past(time_cnt[1]))
    else $error("fraction rollover did not carry");

  a_sec_carry: assert property (
    time_inc[1] && time_cnt[1] == MAX_SEC && !ctrl_wr
    |=> time_cnt[1] == 8'h00 && time_cnt[2] != $past(time_cnt[2]))
    else $error("seconds rollover did not carry");

  a_min_carry: assert property (
    time_inc[2] && time_cnt[2] == MAX_MIN && !ctrl_wr
    |=> time_cnt[2] == 8'h00 && time_cnt[3] != $past(time_cnt[3]))
    else $error("minutes rollover did not carry");

  a_hour_wrap: assert property (
    time_inc[3] && !ctrl_wr &&
    ((sel24_q && time_cnt[3] == MAX_H24) || (!sel24_q && time_cnt[3] == MAX_H256))
    |=> time_cnt[3] == 8'h00)
    else $error("hours did not wrap at limit");

  a_tb_source: assert property (
    interval_enable_q && !timeout && !ctrl_wr && time_inc[tb_q]
    |=> ival_q == $past(ival_q) + 8'h01)
    else $error("selected timebase did not advance interval");

  a_tb_hold: assert property (
    interval_enable_q && !ctrl_wr && !time_inc[tb_q]
    |=> ival_q == $past(ival_q))
    else $error("interval moved without selected tick");

  a_flag_match: assert property (
    timeout |=> flag_q ##1 (flag_q || $past(ctrl_wr)))
    else $error("match did not set flag");

  a_flag_sticky: assert property (
    flag_q && !ctrl_wr |=> flag_q)
    else $error("flag dropped without software write");

  a_wake_up: assert property (
    flag_q && irq_enable_i && core_power_down_i |=> wake_o && irq_vector_o == IRQ_VECTOR)
    else $error("no wake on enabled flag");

  a_single_shot: assert property (
    timeout && single_q && !ctrl_wr |=> !interval_enable_q ##1 ival_q == 8'h00)
    else $error("single shot did not stop interval");

  a_auto_reload: assert property (
    timeout && !single_q && !ctrl_wr |=> interval_enable_q && ival_q == 8'h00)
    else $error("interval did not reload");

  a_ival_clear: assert property (
    !interval_enable_q |=> ival_q == 8'h00)
    else $error("interval counter not cleared");

  a_time_clear: assert property (
    time_clock_enable_fall |=> !time_clock_enable_q && time_cnt[0] == 8'h00 && time_cnt[1] == 8'h00 &&
    time_cnt[2] == 8'h00 && time_cnt[3] == 8'h00)
    else $error("time registers not cleared");

  a_time_frozen: assert property (
    !time_clock_enable_q |-> time_inc == 4'h0 && (!tick128 || $past(time_clock_enable_q)))
    else $error("time advanced while clock off");

  a_preload: assert property (
    !time_clock_enable_q && sfr_req_i.wr && hit(sfr_req_i.addr, OFF_SEC)
    |=> time_cnt[1] == $past(sfr_req_i.wdata))
    else $error("preload of seconds lost");

  a_irq_req: assert property (
    flag_q && irq_enable_i |=> irq_o)
    else $error("no request for enabled flag");

  a_irq_drop: assert property (
    !(flag_q && irq_enable_i) |=> !irq_o)
    else $error("request without enabled flag");

  a_wake_drop: assert property (
    !core_power_down_i |=> !wake_o)
    else $error("wake while core running");

  a_refuse_load: assert property (
    time_clock_enable_q && sfr_req_i.wr && hit(sfr_req_i.addr, OFF_SEC) && !time_inc[1]
    |=> time_cnt[1] == $past(time_cnt[1]))
    else $error("seconds written while clock on");

  a_hold_stop: assert property (
    !time_clock_enable_q && !sfr_req_i.wr
    |=> time_cnt[0] == $past(time_cnt[0]) && time_cnt[3] == $past(time_cnt[3]))
    else $error("time changed while clock off");

  c_hour_roll: cover property (time_inc[3] && time_wrap[3]);
  c_single_timeout: cover property (timeout && single_q);
  c_reload_timeout: cover property (timeout && !single_q ##[1:600] timeout);
  c_wake: cover property (wake_o);
  c_tb_hour: cover property (interval_enable_q && tb_q == TB_HOUR && time_inc[3]);
endmodule

// ### verification/tic_tb.sv
// Self-checking testbench for the time interval counter.
// Assumes tic_top with a shortened prescaler and one 40 MHz clock.
`timescale 1ns/100ps
module testbench;
  import tic_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  localparam int DIV = 4;
  logic clk_i;
  logic rst_n_i;
  tic_sfr_req_t sfr_req_i;
  logic irq_enable_i;
  logic core_power_down_i;
  logic [7:0] sfr_rdata_o;
  logic irq_o;
  logic wake_o;
  logic [15:0] irq_vector_o;
  int mismatches;
  int checks;
  int n;
  logic [7:0] rd;
  logic [7:0] tgt;
  logic h24;

  tic_top #(.FRAC_DIV(DIV)) DUT (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sfr_req_i(sfr_req_i),
    .irq_enable_i(irq_enable_i),
    .core_power_down_i(core_power_down_i),
    .sfr_rdata_o(sfr_rdata_o),
    .irq_o(irq_o),
    .wake_o(wake_o),
    .irq_vector_o(irq_vector_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_req_i <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge clk_i);
    sfr_req_i.wr <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clk_i);
    sfr_req_i.addr <= a;
    @(posedge clk_i);
    #1 rd = sfr_rdata_o;
  endtask

  // Polls control until the flag shows; n counts two-cycle reads
  task automatic wait_flag(input int lim);
    n = 0;
    do begin
      rdr(OFF_CTRL);
      n++;
    end while (rd[BIT_FLAG] !== 1'b1 && n < lim);
  endtask

  function automatic logic [7:0] ctl(input logic h, input logic [1:0] tb, input logic sgl,
                                     input logic interval_enable, input logic time_clock_enable);
    return {1'b0, h, tb, sgl, 1'b0, interval_enable, time_clock_enable};
  endfunction

  function automatic logic [7:0] next_hour(input logic [7:0] hr, input logic h);
    if (h && hr >= MAX_H24) return 8'h00;
    return hr + 8'h01;
  endfunction

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    wrap_up();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(78));
    sfr_req_i = '0;
    irq_enable_i = 1'b0;
    core_power_down_i = 1'b0;
    rst_n_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int a = 'ha1; a <= 'ha7; a++) begin
      rdr(8'(a));
      chk(rd, 8'h00);
    end
    chk(irq_vector_o, IRQ_VECTOR);
    // Preload, start, and watch the full cascade roll
    for (int m = 0; m < 3; m++) begin
      h24 = m[0];
      tgt = (m == 2) ? 8'($urandom_range(0, 22)) : (m[0] ? MAX_H24 : MAX_H256);
      wr(OFF_FRAC, MAX_FRAC);
      wr(OFF_SEC, MAX_SEC);
      wr(OFF_MIN, MAX_MIN);
      wr(OFF_HOUR, tgt);
      rdr(OFF_HOUR);
      chk(rd, tgt);
      wr(OFF_CTRL, ctl(h24, 2'b00, 1'b0, 1'b0, 1'b1));
      wr(OFF_SEC, 8'h05);
      n = 0;
      do begin
        rdr(OFF_FRAC);
        n++;
      end while (rd === MAX_FRAC && n < 20);
      chk(rd, 8'h00);
      rdr(OFF_SEC);
      chk(rd, 8'h00);
      rdr(OFF_MIN);
      chk(rd, 8'h00);
      rdr(OFF_HOUR);
      chk(rd, next_hour(tgt, h24));
      wr(OFF_CTRL, 8'h00);
      rdr(OFF_FRAC);
      chk(rd, 8'h00);
    end
    // Every timebase in single-shot mode
    for (int t = 0; t < 4; t++) begin
      wr(OFF_TARGET, 8'h01);
      // Only the sources below the selected one tick here
      if (t > 0) begin
        if (t > 1) wr(OFF_FRAC, MAX_FRAC);
        if (t > 2) wr(OFF_SEC, MAX_SEC);
        wr(OFF_CTRL, ctl(1'b0, 2'(t), 1'b1, 1'b1, 1'b1));
        repeat (3 * DIV) @(posedge clk_i);
        rdr(OFF_CTRL);
        chk(rd[BIT_FLAG], 1'b0);
        wr(OFF_CTRL, 8'h00);
      end
      if (t > 0) wr(OFF_FRAC, MAX_FRAC);
      if (t > 1) wr(OFF_SEC, MAX_SEC);
      if (t > 2) wr(OFF_MIN, MAX_MIN);
      wr(OFF_CTRL, ctl(1'b0, 2'(t), 1'b1, 1'b1, 1'b1));
      wait_flag(40);
      chk(rd, ctl(1'b0, 2'(t), 1'b1, 1'b0, 1'b1) | 8'h04);
      wr(OFF_CTRL, 8'h00);
    end
    // Auto-reload with a random target, then interrupt paths
    tgt = 8'($urandom_range(5, 8));
    wr(OFF_TARGET, tgt);
    wr(OFF_CTRL, ctl(1'b0, 2'b00, 1'b0, 1'b1, 1'b1));
    wait_flag(100);
    chk({15'h0, (2 * n >= tgt * DIV && 2 * n <= tgt * DIV + 4)}, 16'h0001);
    chk(rd[BIT_INTERVAL_ENABLE], 1'b1);
    chk(irq_o, 1'b0);
    @(posedge clk_i);
    irq_enable_i <= 1'b1;
    core_power_down_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk(irq_o, 1'b1);
    chk(wake_o, 1'b1);
    wr(OFF_CTRL, ctl(1'b0, 2'b00, 1'b0, 1'b0, 1'b1));
    repeat (2) @(posedge clk_i);
    #1 chk(irq_o, 1'b0);
    chk(wake_o, 1'b0);
    // Counter must restart from zero after enable is dropped
    wr(OFF_CTRL, ctl(1'b0, 2'b00, 1'b0, 1'b1, 1'b1));
    repeat (2 * DIV + 1) @(posedge clk_i);
    wr(OFF_CTRL, ctl(1'b0, 2'b00, 1'b0, 1'b0, 1'b1));
    wr(OFF_CTRL, ctl(1'b0, 2'b00, 1'b0, 1'b1, 1'b1));
    wait_flag(100);
    chk({15'h0, (2 * n > (tgt - 1) * DIV && 2 * n <= tgt * DIV + 4)}, 16'h0001);
    wrap_up();
  end
endmodule
